// File: src/rcid_decoder.sv
// Run command input decoder: two-wire and three-wire control of run/stop
`timescale 1ns/10ps
module rcid_decoder #(
    parameter int HOLD_CYCLES = rcid_pkg::HOLD_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Logic input pins: first_logic_input is forward (two-wire) or stop (three-wire), the second is forward in three-wire only
    input  wire logic              first_logic_input,
    input  wire logic              second_logic_input,
    input  wire logic              reverse_input,
    // Keypad settings
    input  wire logic              confirm_key,
    input  wire logic [1:0]        scheme_request,
    input  wire logic              style_write,
    input  wire logic [1:0]        style_request,
    input  wire logic              polarity_write,
    input  wire logic [1:0]        polarity_request,
    // Settings and state visible to the keypad
    output rcid_pkg::rcid_cfg_s    active_cfg,
    output logic [1:0]             stored_polarity,
    output logic                   style_visible,
    output logic                   assignments_reset,
    // Commands
    output rcid_pkg::rcid_cmd_s    cmd,
    output rcid_pkg::rcid_run_e    run_state
);

    if (HOLD_CYCLES < 2)
    begin : g_hold_check
        $error("HOLD_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [2:0]          sync1;
        logic [2:0]          sync2;
        logic [2:0]          prev;
        logic                armed;
        rcid_pkg::rcid_cfg_s cfg;
        logic [1:0]          pol_store;
        logic                asg_reset;
        rcid_pkg::rcid_cmd_s cmd;
        rcid_pkg::rcid_run_e run;
    } rcid_state_s;

    rcid_state_s st;
    rcid_state_s next_st;
    logic        hold_done;
    logic [2:0]  lvl;
    logic [2:0]  rise;
    logic        fwd_in;
    logic        rev_in;
    logic        stop_in;
    logic        neg_pol;
    logic        scheme_change;
    logic        arm_two;
    rcid_pkg::rcid_run_e run_three;
    rcid_pkg::rcid_run_e run_two;

    ////////////////////////////////////////////////////////////////////////
    // Keypad hold timer for the scheme setting; only a legal scheme that
    // differs from the current one arms it
    assign scheme_change = confirm_key && (scheme_request != st.cfg.scheme) &&
                           (scheme_request <= rcid_pkg::SCHEME_THREE_WIRE);

    rcid_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .key_held    (scheme_change),
        .hold_done   (hold_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Polarity is applied after the synchroniser; bit 0 is first_logic_input
    assign neg_pol = (st.cfg.polarity != rcid_pkg::POL_POSITIVE);

    for (genvar i = 0; i < $bits(lvl); i++)
    begin : g_input
        assign lvl[i]  = st.sync2[i] ^ neg_pol;
        assign rise[i] = lvl[i] & ~st.prev[i];
    end

    // Three-wire reads forward from the second pin, two-wire from the first
    assign fwd_in  = (st.cfg.scheme == rcid_pkg::SCHEME_THREE_WIRE) ? lvl[1] : lvl[0];
    assign rev_in  = lvl[2];
    assign stop_in = lvl[0];

    ////////////////////////////////////////////////////////////////////////
    // Three-wire: the stop input must stand at 1 before any run is accepted
    always_comb
    begin
        run_three = st.run;
        // A stop edge wins over a simultaneous run edge, for safety
        if (rise[0] || !stop_in)
            run_three = rcid_pkg::RCID_STOP;
        else if (rise[1])
            run_three = rcid_pkg::RCID_RUN_FWD;
        else if (rise[2])
            run_three = rcid_pkg::RCID_RUN_REV;
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire: level, transition and forward-wins styles
    always_comb
    begin
        run_two = st.run;
        arm_two = st.armed;
        case (st.cfg.style)
            rcid_pkg::STYLE_LEVEL:
                run_two = fwd_in ? rcid_pkg::RCID_RUN_FWD :
                          rev_in ? rcid_pkg::RCID_RUN_REV : rcid_pkg::RCID_STOP;
            rcid_pkg::STYLE_TRANSITION:
            begin
                // Standing level after restart needs a release before a start
                if (!fwd_in && !rev_in)
                    arm_two = 1'b1;
                if (!fwd_in && !rev_in)
                    run_two = rcid_pkg::RCID_STOP;
                else if (st.run == rcid_pkg::RCID_STOP && st.armed)
                    run_two = (rise[0] ? rcid_pkg::RCID_RUN_FWD :
                               rise[2] ? rcid_pkg::RCID_RUN_REV :
                               rcid_pkg::RCID_STOP);
                else if (st.run == rcid_pkg::RCID_RUN_FWD && !fwd_in)
                    run_two = rcid_pkg::RCID_STOP;
                else if (st.run == rcid_pkg::RCID_RUN_REV && !rev_in)
                    run_two = rcid_pkg::RCID_STOP;
            end
            rcid_pkg::STYLE_FORWARD_WIN:
                // Forward is tested first, so it wins when both stand at 1
                run_two = fwd_in ? rcid_pkg::RCID_RUN_FWD :
                          rev_in ? rcid_pkg::RCID_RUN_REV : rcid_pkg::RCID_STOP;
            default:
                run_two = rcid_pkg::RCID_STOP;
        endcase
        // Level style: both asserted is contradictory, so stop
        if (st.cfg.style == rcid_pkg::STYLE_LEVEL && fwd_in && rev_in)
            run_two = rcid_pkg::RCID_STOP;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: synchroniser, settings and the decision of the active scheme
    always_comb
    begin
        next_st           = st;
        next_st.sync1     = {reverse_input, second_logic_input, first_logic_input};
        next_st.sync2     = st.sync1;
        next_st.prev      = lvl;
        next_st.asg_reset = 1'b0;
        // Stored only; takes effect at the next restart
        if (polarity_write)
            next_st.pol_store = polarity_request;
        // Style edits ignored unless two-wire
        if (style_write && st.cfg.scheme == rcid_pkg::SCHEME_TWO_WIRE)
            next_st.cfg.style = style_request;
        if (hold_done)
        begin
            // New scheme starts stopped, with style and assignments at defaults
            next_st.cfg.scheme = scheme_request;
            next_st.cfg.style  = rcid_pkg::DEF_STYLE;
            next_st.asg_reset  = 1'b1;
            next_st.run        = rcid_pkg::RCID_STOP;
            next_st.armed      = 1'b0;
        end
        else if (st.cfg.scheme == rcid_pkg::SCHEME_THREE_WIRE)
            next_st.run = run_three;
        else
        begin
            next_st.run   = run_two;
            next_st.armed = arm_two;
        end
        // Command outputs are registered copies of the decision
        next_st.cmd.run_fwd = (next_st.run == rcid_pkg::RCID_RUN_FWD);
        next_st.cmd.run_rev = (next_st.run == rcid_pkg::RCID_RUN_REV);
        next_st.cmd.stop    = (next_st.run == rcid_pkg::RCID_STOP);
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset is the restart: stored polarity becomes active only here.
    // The synchroniser keeps sampling through reset and the last level reads
    // as all ones, so a level already standing at release is never an edge.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st              <= '0;
            st.sync1        <= {reverse_input, second_logic_input, first_logic_input};
            st.sync2        <= st.sync1;
            st.prev         <= '1;
            st.cfg.scheme   <= rcid_pkg::DEF_SCHEME;
            st.cfg.style    <= rcid_pkg::DEF_STYLE;
            st.cfg.polarity <= st.pol_store;
            st.pol_store    <= st.pol_store;
            st.cmd.stop     <= 1'b1;
            st.run          <= rcid_pkg::RCID_STOP;
        end
        else if (ce)
            st <= next_st;
    end

    assign active_cfg        = st.cfg;
    assign stored_polarity   = st.pol_store;
    assign style_visible     = (st.cfg.scheme == rcid_pkg::SCHEME_TWO_WIRE);
    assign assignments_reset = st.asg_reset;
    assign cmd               = st.cmd;
    assign run_state         = st.run;

endmodule : rcid_decoder

// File: src/rcid_pkg.sv
// Shared constants and carrier types for the run command input decoder
package rcid_pkg;

    // Wiring scheme codes
    localparam logic [1:0] SCHEME_TWO_WIRE   = 2'h0;
    localparam logic [1:0] SCHEME_THREE_WIRE = 2'h1;

    // Two-wire style codes
    localparam logic [1:0] STYLE_LEVEL       = 2'h0;
    localparam logic [1:0] STYLE_TRANSITION  = 2'h1;
    localparam logic [1:0] STYLE_FORWARD_WIN = 2'h2;

    // Input polarity codes
    localparam logic [1:0] POL_POSITIVE      = 2'h0;
    localparam logic [1:0] POL_NEG_INTERNAL  = 2'h1;
    localparam logic [1:0] POL_NEG_EXTERNAL  = 2'h2;

    // Factory defaults
    localparam logic [1:0] DEF_SCHEME        = SCHEME_TWO_WIRE;
    localparam logic [1:0] DEF_STYLE         = STYLE_TRANSITION;
    localparam logic [1:0] DEF_POLARITY      = POL_POSITIVE;

    // Hold time of the confirm key
    localparam int         CLK_HZ            = 125000000;
    localparam int         HOLD_MS           = 2000;
    localparam int         HOLD_CYCLES       = (CLK_HZ / 1000) * HOLD_MS;

    typedef enum logic [1:0] {
        RCID_STOP    = 2'b00,
        RCID_RUN_FWD = 2'b01,
        RCID_RUN_REV = 2'b10
    } rcid_run_e;

    // Settings carried between the keypad logic and the decoder
    typedef struct packed {
        logic [1:0] scheme;
        logic [1:0] style;
        logic [1:0] polarity;
    } rcid_cfg_s;

    // Decoded commands
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic stop;
    } rcid_cmd_s;

endpackage : rcid_pkg

// File: src/rcid_hold_timer.sv
// Confirm key hold timer: one pulse after the key is held long enough
`timescale 1ns/10ps
module rcid_hold_timer #(
    parameter int HOLD_CYCLES = rcid_pkg::HOLD_CYCLES
) (
    // Clock, reset and enable
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Key
    input  wire logic key_held,
    output logic      hold_done
);

    if (HOLD_CYCLES < 2)
    begin : g_hold_check
        $error("HOLD_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [31:0] count;
        logic        fired;
        logic        done;
    } rcid_hold_s;

    rcid_hold_s st;
    rcid_hold_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // Counts only while held; release restarts, so short presses never fire
    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        if (!key_held)
        begin
            next_st.count = 32'h0;
            next_st.fired = 1'b0;
        end
        else if (!st.fired)
        begin
            if (st.count == 32'(HOLD_CYCLES - 1))
            begin
                next_st.done  = 1'b1;
                next_st.fired = 1'b1;
            end
            else
                next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign hold_done = st.done;

endmodule : rcid_hold_timer

// File: test/rcid_switch_model.sv
// Partner model: switches wired to the three logic input pins
`timescale 1ns/10ps
module rcid_switch_model (
    // Wiring polarity and wanted logical states
    input  wire logic neg,
    input  wire logic st1,
    input  wire logic st2,
    input  wire logic str,
    // Pins
    output logic      pin1,
    output logic      pin2,
    output logic      pinr
);
    // Sink wiring pulls a pin low to assert it
    assign pin1 = st1 ^ neg;
    assign pin2 = st2 ^ neg;
    assign pinr = str ^ neg;
endmodule : rcid_switch_model

// File: test/rcid_assertions.sv
// Port checks for the run command input decoder
`timescale 1ns/10ps
module rcid_assertions #(
    parameter int HOLD_CYCLES = 20
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Pins and key
    input  wire logic                first_logic_input,
    input  wire logic                reverse_input,
    input  wire logic                confirm_key,
    // Outputs
    input  wire rcid_pkg::rcid_cfg_s active_cfg,
    input  wire logic                style_visible,
    input  wire logic                assignments_reset,
    input  wire rcid_pkg::rcid_cmd_s cmd
);
    logic        f;
    logic        r;
    logic        two;
    logic [31:0] hold_cnt;
    // Logical states as the decoder should read them
    assign f   = first_logic_input ^ (active_cfg.polarity != rcid_pkg::POL_POSITIVE);
    assign r   = reverse_input ^ (active_cfg.polarity != rcid_pkg::POL_POSITIVE);
    assign two = active_cfg.scheme == rcid_pkg::SCHEME_TWO_WIRE;
    always_ff @(posedge clk)
    begin
        hold_cnt <= (rst || !confirm_key) ? 32'h0 : hold_cnt + 32'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_cmd_one_hot: assert property ($onehot(cmd))
        else $error("command not one-hot");
    a_style_shown: assert property (style_visible == two)
        else $error("style visibility wrong");
    a_scheme_side: assert property (!$past(rst) && $changed(active_cfg.scheme) |->
        assignments_reset && active_cfg.style == rcid_pkg::STYLE_TRANSITION)
        else $error("scheme change side effects missing");
    a_pol_frozen: assert property (!$past(rst) |-> $stable(active_cfg.polarity))
        else $error("polarity changed without restart");
    a_fwd_wins: assert property ((two && active_cfg.style == rcid_pkg::STYLE_FORWARD_WIN
        && f && r) [*4] |-> cmd.run_fwd)
        else $error("forward did not win");
    a_cold_level: assert property ($fell(rst) && f ##1 f [*5] |-> cmd.stop)
        else $error("standing level started the motor");
    a_three_stop: assert property ((!two && !f) [*4] |-> cmd.stop)
        else $error("run without stop input");
    a_hold_long: assert property (!$past(rst) && $changed(active_cfg.scheme) |->
        $past(hold_cnt) >= HOLD_CYCLES)
        else $error("scheme taken after a short press");
endmodule : rcid_assertions

bind rcid_decoder rcid_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .first_logic_input(first_logic_input),
    .reverse_input(reverse_input), .confirm_key(confirm_key), .active_cfg(active_cfg),
    .style_visible(style_visible), .assignments_reset(assignments_reset), .cmd(cmd));

// File: test/tb_top.sv
// Self-checking bench for the run command input decoder
`timescale 1ns/10ps
module tb_top;
    localparam int                  HOLD = 20;
    localparam rcid_pkg::rcid_cmd_s STP = 3'h1;
    localparam rcid_pkg::rcid_cmd_s REV = 3'h2;
    localparam rcid_pkg::rcid_cmd_s FWD = 3'h4;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                ce = 1'b1;
    logic                neg = 1'b0;
    logic                s1 = 1'b0;
    logic                s2 = 1'b0;
    logic                sr = 1'b0;
    logic                p1;
    logic                p2;
    logic                pr;
    logic                key = 1'b0;
    logic [1:0]          sch_req = 2'h0;
    logic                sty_wr = 1'b0;
    logic [1:0]          sty_req = 2'h0;
    logic                pol_wr = 1'b0;
    logic [1:0]          pol_req = 2'h0;
    rcid_pkg::rcid_cfg_s cfg;
    logic [1:0]          pend;
    logic                vis;
    rcid_pkg::rcid_cmd_s cmd;
    rcid_pkg::rcid_run_e rs;
    logic                asg;
    logic [1:0]          asg_cnt = 2'h0;
    int                  miscompares = 0;
    int                  compares = 0;
    always #4 clk = ~clk;
    // Counts scheme-change pulses, which stand for one cycle only
    always @(posedge clk)
        if (asg)
            asg_cnt <= asg_cnt + 2'h1;
    rcid_switch_model u_sw (.neg(neg), .st1(s1), .st2(s2), .str(sr),
        .pin1(p1), .pin2(p2), .pinr(pr));
    rcid_decoder #(.HOLD_CYCLES(HOLD)) u_dut (.clk(clk), .rst(rst), .ce(ce),
        .first_logic_input(p1), .second_logic_input(p2), .reverse_input(pr),
        .confirm_key(key), .scheme_request(sch_req), .style_write(sty_wr),
        .style_request(sty_req), .polarity_write(pol_wr), .polarity_request(pol_req),
        .active_cfg(cfg), .stored_polarity(pend), .style_visible(vis),
        .assignments_reset(asg), .cmd(cmd), .run_state(rs));
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk_cmd(input rcid_pkg::rcid_cmd_s e);
        rcid_pkg::rcid_run_e w;
        w = e.run_fwd ? rcid_pkg::RCID_RUN_FWD :
            e.run_rev ? rcid_pkg::RCID_RUN_REV : rcid_pkg::RCID_STOP;
        compares++;
        if (cmd !== e || rs !== w)
        begin
            miscompares++;
            $display("wrong value at %0t: cmd %b state %h want %b", $time, cmd, rs, e);
        end
    endtask : chk_cmd
    task automatic chk_two(input logic [1:0] g, input logic [1:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: field %h want %h", $time, g, e);
        end
    endtask : chk_two
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic restart();
        rst = 1'b1;
        step(4);
        rst = 1'b0;
    endtask : restart
    task automatic pins(input logic a, input logic b, input logic r);
        s1 = a;
        s2 = b;
        sr = r;
        step(4);
    endtask : pins
    task automatic set_style(input logic [1:0] v);
        sty_req = v;
        sty_wr = 1'b1;
        step(1);
        sty_wr = 1'b0;
        step(1);
    endtask : set_style
    task automatic set_pol(input logic [1:0] v);
        pol_req = v;
        pol_wr = 1'b1;
        step(1);
        pol_wr = 1'b0;
        step(1);
    endtask : set_pol
    task automatic hold_key(input logic [1:0] s, input int n);
        sch_req = s;
        key = 1'b1;
        step(n);
        key = 1'b0;
        step(2);
    endtask : hold_key
    ////////////////////////////////////////
    task automatic t_cold_start();
        s1 = 1'b1;
        restart();
        step(6);
        chk_cmd(STP);
        pins(1'b0, 1'b0, 1'b0);
        s1 = 1'b1;
        step(1);
        chk_cmd(STP);
        step(3);
        chk_cmd(FWD);
        pins(1'b0, 1'b0, 1'b0);
        chk_cmd(STP);
    endtask : t_cold_start
    task automatic t_styles();
        set_style(rcid_pkg::STYLE_LEVEL);
        pins(1'b1, 1'b0, 1'b0);
        chk_cmd(FWD);
        pins(1'b0, 1'b0, 1'b1);
        chk_cmd(REV);
        pins(1'b1, 1'b0, 1'b1);
        chk_cmd(STP);
        pins(1'b0, 1'b0, 1'b0);
        set_style(rcid_pkg::STYLE_FORWARD_WIN);
        pins(1'b1, 1'b0, 1'b1);
        chk_cmd(FWD);
        pins(1'b0, 1'b0, 1'b0);
        chk_cmd(STP);
    endtask : t_styles
    task automatic t_polarity();
        for (int p = 1; p < 3; p++)
        begin
            set_pol(p[1:0]);
            chk_two(cfg.polarity, 2'(p - 1));
            chk_two(pend, p[1:0]);
            neg = 1'b1;
            restart();
            chk_two(cfg.polarity, p[1:0]);
            set_style(rcid_pkg::STYLE_LEVEL);
            pins(1'b1, 1'b0, 1'b0);
            chk_cmd(FWD);
            pins(1'b0, 1'b0, 1'b0);
        end
        set_pol(rcid_pkg::POL_POSITIVE);
        neg = 1'b0;
        restart();
    endtask : t_polarity
    task automatic t_scheme();
        set_style(rcid_pkg::STYLE_LEVEL);
        hold_key(rcid_pkg::SCHEME_THREE_WIRE, 5);
        chk_two(cfg.scheme, rcid_pkg::SCHEME_TWO_WIRE);
        chk_two(asg_cnt, 2'h0);
        hold_key(rcid_pkg::SCHEME_THREE_WIRE, HOLD + 4);
        chk_two(cfg.scheme, rcid_pkg::SCHEME_THREE_WIRE);
        chk_two(cfg.style, rcid_pkg::STYLE_TRANSITION);
        chk_two(asg_cnt, 2'h1);
        chk_two({1'b0, vis}, 2'h0);
        set_style(rcid_pkg::STYLE_LEVEL);
        chk_two(cfg.style, rcid_pkg::STYLE_TRANSITION);
        pins(1'b1, 1'b0, 1'b0);
        chk_cmd(STP);
        pins(1'b1, 1'b1, 1'b0);
        pins(1'b1, 1'b0, 1'b0);
        chk_cmd(FWD);
        pins(1'b1, 1'b0, 1'b1);
        chk_cmd(REV);
        pins(1'b0, 1'b0, 1'b0);
        chk_cmd(STP);
        hold_key(rcid_pkg::SCHEME_TWO_WIRE, HOLD + 4);
        chk_two({1'b0, vis}, 2'h1);
        chk_two(asg_cnt, 2'h2);
    endtask : t_scheme
    ////////////////////////////////////////
    // The stored polarity survives reset, so it is written once between two resets
    initial
    begin
        step(4);
        rst = 1'b0;
        set_pol(rcid_pkg::POL_POSITIVE);
        t_cold_start();
        t_styles();
        t_polarity();
        t_scheme();
        wrap_up();
    end
    initial
    begin
        #50000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
